/* File: inc/nibble_xfer_pkg.sv */
// Constants, types and register map of the nibble transfer executor
package nibble_xfer_pkg;

  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Core register widths
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 3;
  localparam int OPC_W = 10;
  localparam int CNT_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ACC = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_AUX = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PTR = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ1 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;

  // Control register fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_CARRY_BIT = 1;

  // Status register fields
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_UNKNOWN_BIT = 1;
  localparam int STAT_KIND_LSB = 2;
  localparam int STAT_CNT_LSB = 8;

  // Byte lanes
  localparam int LANE0 = 0;
  localparam int LANE1 = 1;
  localparam int LANE0_MSB = 7;
  localparam int LANE1_LSB = 8;

  // Field positions inside the core registers
  localparam int SHIFT_HI_MSB = 7;
  localparam int SHIFT_HI_LSB = 4;
  localparam int SHIFT_LO_MSB = 3;
  localparam int CMP_HI_MSB = 7;
  localparam int CMP_HI_LSB = 4;

  // Reset values
  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 3'h0;
  localparam logic [OPC_W-1:0] RST_OPC = 10'h000;
  localparam logic [CNT_W-1:0] RST_CNT = 8'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Opcodes handled by this block
  localparam logic [OPC_W-1:0] OPC_SHIFT_RD = 10'h278;
  localparam logic [OPC_W-1:0] OPC_PTR_RD = 10'h051;
  localparam logic [OPC_W-1:0] OPC_CMP_WR = 10'h239;
  localparam logic [OPC_W-1:0] OPC_IRQ_RD = 10'h253;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_SHIFT_RD = 3'b001,
    KIND_PTR_RD = 3'b010,
    KIND_CMP_WR = 3'b011,
    KIND_IRQ_RD = 3'b100
  } instr_kind_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

endpackage : nibble_xfer_pkg

/* File: inc/exec_if.sv */
// Signals shared by the top, the decoder and the execution unit
`timescale 1ns/10ps
interface exec_if;
  import nibble_xfer_pkg::*;

  logic [OPC_W-1:0] opcode;
  instr_kind_t kind;
  logic [NIB_W-1:0] acc;
  logic [NIB_W-1:0] aux;
  logic [BYTE_W-1:0] shift;
  logic [PTR_W-1:0] ptr;
  logic [NIB_W-1:0] irq1;
  logic mode;
  logic [NIB_W-1:0] new_acc;
  logic [NIB_W-1:0] new_aux;
  logic [BYTE_W-1:0] new_cmp;
  logic acc_we;
  logic aux_we;
  logic cmp_we;

  modport top (
    output opcode, acc, aux, shift, ptr, irq1, mode,
    input kind, new_acc, new_aux, new_cmp, acc_we, aux_we, cmp_we
  );
  modport decoder (
    input opcode,
    output kind
  );
  modport executor (
    input kind, acc, aux, shift, ptr, irq1, mode,
    output new_acc, new_aux, new_cmp, acc_we, aux_we, cmp_we
  );

endinterface : exec_if

/* File: design/opcode_decoder.sv */
// Maps a 10-bit opcode onto one of the handled transfer kinds
`timescale 1ns/10ps
module opcode_decoder (
  exec_if.decoder dec
);
  import nibble_xfer_pkg::*;

  function automatic instr_kind_t decode_opcode(
    input logic [OPC_W-1:0] opc
  );
    instr_kind_t k;
    case (opc)
      OPC_SHIFT_RD: k = KIND_SHIFT_RD;
      OPC_PTR_RD: k = KIND_PTR_RD;
      OPC_CMP_WR: k = KIND_CMP_WR;
      OPC_IRQ_RD: k = KIND_IRQ_RD;
      default: k = KIND_NONE;
    endcase
    return k;
  endfunction : decode_opcode

  always_comb
  begin
    dec.kind = decode_opcode(dec.opcode);
  end

endmodule : opcode_decoder

/* File: design/transfer_exec.sv */
// Works out the register updates of one transfer instruction
`timescale 1ns/10ps
module transfer_exec (
  exec_if.executor ex
);
  import nibble_xfer_pkg::*;

  always_comb
  begin
    ex.new_acc = ex.acc;
    ex.new_aux = ex.aux;
    ex.new_cmp = {ex.aux, ex.acc};
    ex.acc_we = 1'b0;
    ex.aux_we = 1'b0;
    ex.cmp_we = 1'b0;
    case (ex.kind)
      KIND_SHIFT_RD:
      begin
        // High half to aux, low half to acc; shift register untouched
        ex.new_aux = ex.shift[SHIFT_HI_MSB:SHIFT_HI_LSB];
        ex.new_acc = ex.shift[SHIFT_LO_MSB:0];
        ex.aux_we = 1'b1;
        ex.acc_we = 1'b1;
      end
      KIND_PTR_RD:
      begin
        ex.new_acc = {1'b0, ex.ptr};
        ex.acc_we = 1'b1;
      end
      KIND_CMP_WR:
      begin
        // Conversion mode leaves every register alone
        ex.cmp_we = ex.mode;
      end
      KIND_IRQ_RD:
      begin
        ex.new_acc = ex.irq1;
        ex.acc_we = 1'b1;
      end
      default:
      begin
        ex.acc_we = 1'b0;
      end
    endcase
  end

endmodule : transfer_exec

/* File: design/nibble_transfer_instr_exec.sv */
// Register-transfer instruction executor with an Avalon-MM register port
// Function
// - Shift read splits shift register into aux, acc
// - Pointer read copies pointer into acc bits 2..0
// - Pointer read clears acc bit 3
// - Comparator write in comparator mode loads aux, acc
// - Comparator write in conversion mode changes nothing
// - Interrupt-control read copies its register into acc
// - Shift read targets aux high, acc low; shift kept
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module nibble_transfer_instr_exec (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [nibble_xfer_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [nibble_xfer_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [nibble_xfer_pkg::BE_W-1:0] avs_byteenable,
  output logic [nibble_xfer_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [nibble_xfer_pkg::BYTE_W-1:0] cmp_value,
  output logic exec_done,
  output logic skip_next,
  output logic carry_flag
);
  import nibble_xfer_pkg::*;

  typedef struct packed {
    bus_state_t bus;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] aux;
    logic [BYTE_W-1:0] shift;
    logic [PTR_W-1:0] ptr;
    logic [BYTE_W-1:0] cmp;
    logic [NIB_W-1:0] irq1;
    logic mode;
    logic carry;
    logic [OPC_W-1:0] opcode;
    logic pending;
    logic done;
    logic skip;
    instr_kind_t last_kind;
    logic unknown;
    logic [CNT_W-1:0] count;
  } state_t;

  state_t st;
  state_t next_st;

  exec_if xif ();

  opcode_decoder u_decoder (
    .dec(xif.decoder)
  );

  transfer_exec u_exec (
    .ex(xif.executor)
  );

  // Current register values feed the decoder and execution unit
  assign xif.opcode = st.opcode;
  assign xif.acc = st.acc;
  assign xif.aux = st.aux;
  assign xif.shift = st.shift;
  assign xif.ptr = st.ptr;
  assign xif.irq1 = st.irq1;
  assign xif.mode = st.mode;

  function automatic logic [DATA_W-1:0] read_word(
    input state_t s,
    input logic [ADDR_W-1:0] addr
  );
    logic [DATA_W-1:0] w;
    // Unmapped offsets and unused bits read as zero
    w = RST_WORD;
    case (addr)
      OFS_ACC:
      begin
        w[NIB_W-1:0] = s.acc;
      end
      OFS_AUX:
      begin
        w[NIB_W-1:0] = s.aux;
      end
      OFS_SHIFT:
      begin
        w[BYTE_W-1:0] = s.shift;
      end
      OFS_PTR:
      begin
        w[PTR_W-1:0] = s.ptr;
      end
      OFS_CMP:
      begin
        w[BYTE_W-1:0] = s.cmp;
      end
      OFS_IRQ1:
      begin
        w[NIB_W-1:0] = s.irq1;
      end
      OFS_CTRL:
      begin
        w[CTRL_MODE_BIT] = s.mode;
        w[CTRL_CARRY_BIT] = s.carry;
      end
      OFS_INSTR:
      begin
        w[OPC_W-1:0] = s.opcode;
      end
      OFS_STATUS:
      begin
        w[STAT_PEND_BIT] = s.pending;
        w[STAT_UNKNOWN_BIT] = s.unknown;
        w[STAT_KIND_LSB +: $bits(instr_kind_t)] = s.last_kind;
        w[STAT_CNT_LSB +: CNT_W] = s.count;
      end
      default:
      begin
        w = RST_WORD;
      end
    endcase
    return w;
  endfunction : read_word

  // Byte lane test for the instruction word lanes
  function automatic logic lane_on(
    input logic [BE_W-1:0] be,
    input int lane
  );
    return be[lane];
  endfunction : lane_on

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.skip = 1'b0;

    // Execute the instruction written in the previous access
    if (st.pending)
    begin
      next_st.pending = 1'b0;
      next_st.done = 1'b1;
      next_st.last_kind = xif.kind;
      next_st.unknown = (xif.kind == KIND_NONE);
      next_st.count = st.count + CNT_ONE;
      if (xif.acc_we)
      begin
        next_st.acc = xif.new_acc;
      end
      if (xif.aux_we)
      begin
        next_st.aux = xif.new_aux;
      end
      if (xif.cmp_we)
      begin
        next_st.cmp = xif.new_cmp;
      end
      // Carry and skip are never touched by these transfers
      next_st.carry = st.carry;
    end

    case (st.bus)
      BUS_IDLE:
      begin
        next_st.waitreq = 1'b1;
        if (avs_read || avs_write)
        begin
          next_st.bus = BUS_ACK;
          next_st.waitreq = 1'b0;
          if (avs_read)
          begin
            next_st.rdata = read_word(st, avs_address);
          end
        end
      end
      BUS_ACK:
      begin
        // A write lands at the edge that completes the handshake
        next_st.bus = BUS_IDLE;
        next_st.waitreq = 1'b1;
        if (avs_write)
        begin
          case (avs_address)
            OFS_ACC:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.acc = avs_writedata[NIB_W-1:0];
              end
            end
            OFS_AUX:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.aux = avs_writedata[NIB_W-1:0];
              end
            end
            OFS_SHIFT:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.shift = avs_writedata[BYTE_W-1:0];
              end
            end
            OFS_PTR:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.ptr = avs_writedata[PTR_W-1:0];
              end
            end
            OFS_CMP:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.cmp = avs_writedata[BYTE_W-1:0];
              end
            end
            OFS_IRQ1:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.irq1 = avs_writedata[NIB_W-1:0];
              end
            end
            OFS_CTRL:
            begin
              if (avs_byteenable[LANE0])
              begin
                next_st.mode = avs_writedata[CTRL_MODE_BIT];
                next_st.carry = avs_writedata[CTRL_CARRY_BIT];
              end
            end
            OFS_INSTR:
            begin
              // One program word per instruction; it runs next cycle
              if (lane_on(avs_byteenable, LANE0))
              begin
                next_st.opcode[LANE0_MSB:0] = avs_writedata[LANE0_MSB:0];
              end
              if (lane_on(avs_byteenable, LANE1))
              begin
                next_st.opcode[OPC_W-1:LANE1_LSB] =
                  avs_writedata[OPC_W-1:LANE1_LSB];
              end
              next_st.pending = lane_on(avs_byteenable, LANE0) ||
                lane_on(avs_byteenable, LANE1);
            end
            default:
            begin
              next_st.bus = BUS_IDLE;
            end
          endcase
        end
      end
      default:
      begin
        next_st.bus = BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase
  end

  // Every field has a constant reset value; ce low freezes all of them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.bus <= BUS_IDLE;
      st.waitreq <= 1'b1;
      st.rdata <= RST_WORD;
      st.acc <= RST_NIB;
      st.aux <= RST_NIB;
      st.shift <= RST_BYTE;
      st.ptr <= RST_PTR;
      st.cmp <= RST_BYTE;
      st.irq1 <= RST_NIB;
      st.mode <= 1'b0;
      st.carry <= 1'b0;
      st.opcode <= RST_OPC;
      st.pending <= 1'b0;
      st.done <= 1'b0;
      st.skip <= 1'b0;
      st.last_kind <= KIND_NONE;
      st.unknown <= 1'b0;
      st.count <= RST_CNT;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign cmp_value = st.cmp;
  assign exec_done = st.done;
  assign skip_next = st.skip;
  assign carry_flag = st.carry;

endmodule : nibble_transfer_instr_exec

/* File: verif/nibble_xfer_properties.sv */
// Port-level checks of the transfer executor
`timescale 1ns/10ps
module nibble_xfer_properties (
  input logic core_clk,
  input logic rst_n,
  input logic ce,
  input logic [nibble_xfer_pkg::ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [nibble_xfer_pkg::DATA_W-1:0] avs_writedata,
  input logic [nibble_xfer_pkg::BE_W-1:0] avs_byteenable,
  input logic [nibble_xfer_pkg::DATA_W-1:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [nibble_xfer_pkg::BYTE_W-1:0] cmp_value,
  input logic exec_done,
  input logic skip_next,
  input logic carry_flag
);
  import nibble_xfer_pkg::*;
  wire wr_done = avs_write && !avs_waitrequest;
  wire op_ok = avs_writedata[OPC_W-1:0] inside
    {OPC_SHIFT_RD, OPC_PTR_RD, OPC_CMP_WR, OPC_IRQ_RD};
  wire instr_wr = wr_done && avs_address == OFS_INSTR;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);

  a_answer_one_cycle: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
  a_answer_is_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_upper_zero: assert property (!avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_rdata_hold: assert property ($changed(avs_readdata) |->
    !avs_waitrequest && $past(avs_read)) else $error("read data moved");
  a_done_after_issue: assert property (instr_wr && op_ok &&
    avs_byteenable[1:0] == 2'b11 |=> ##1 exec_done)
    else $error("instruction did not finish in one cycle");
  a_done_one_cycle: assert property (exec_done |=> !exec_done)
    else $error("done pulse too long");
  a_carry_only_ctrl: assert property ($changed(carry_flag) |->
    $past(wr_done && avs_address == OFS_CTRL)) else $error("carry moved");
  a_cmp_only_exec: assert property ($changed(cmp_value) |->
    exec_done || $past(wr_done && avs_address == OFS_CMP))
    else $error("comparator moved without cause");
  a_never_skip: assert property (skip_next == 1'b0)
    else $error("skip raised");

  c_exec: cover property (exec_done);
  c_cmp_load: cover property ($changed(cmp_value));
  c_carry_set: cover property ($rose(carry_flag));
endmodule : nibble_xfer_properties

bind nibble_transfer_instr_exec nibble_xfer_properties u_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .ce(ce),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .cmp_value(cmp_value),
  .exec_done(exec_done),
  .skip_next(skip_next),
  .carry_flag(carry_flag)
);

/* File: verif/avalon_host_model.sv */
// Avalon-MM master standing in for the software side
`timescale 1ns/10ps
module avalon_host_model (
  input logic core_clk,
  output logic [nibble_xfer_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [nibble_xfer_pkg::DATA_W-1:0] avs_writedata,
  output logic [nibble_xfer_pkg::BE_W-1:0] avs_byteenable,
  input logic [nibble_xfer_pkg::DATA_W-1:0] avs_readdata,
  input logic avs_waitrequest
);
  import nibble_xfer_pkg::*;
  initial
  begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
  end

  // Holds the request until waitrequest is seen low, then releases it
  task xfer(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be,
    output logic [DATA_W-1:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released address and data lines do not keep their last value
    avs_writedata <= ~d;
    avs_address <= ~a;
  endtask : xfer
endmodule : avalon_host_model

/* File: verif/nibble_transfer_instr_exec_tb_top.sv */
// Self-checking bench of the transfer executor
`timescale 1ns/10ps
module nibble_transfer_instr_exec_tb_top;
  import nibble_xfer_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0] avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [BYTE_W-1:0] cmp_value;
  logic exec_done;
  logic skip_next;
  logic carry_flag;
  logic [DATA_W-1:0] q;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 core_clk = ~core_clk;

  avalon_host_model host (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  nibble_transfer_instr_exec dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_value(cmp_value),
    .exec_done(exec_done), .skip_next(skip_next),
    .carry_flag(carry_flag));

  task chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.xfer(1'b1, a, d, 4'hF, q);
  endtask : wr

  task rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, e);
  endtask : rc

  // Execution lands one cycle after the write; done rises in the same cycle
  task issue(input logic [OPC_W-1:0] opc);
    wr(OFS_INSTR, {22'h00_0000, opc});
    repeat (3) @(posedge core_clk);
  endtask : issue

  task t_reset_map;
    for (int i = 0; i < 9; i++) rc(ADDR_W'(i * 4), 32'h0000_0000);
    chk({24'h00_0000, cmp_value}, 32'h0000_0000);
    wr(6'h3C, 32'hFFFF_FFFF);
    rc(6'h3C, 32'h0000_0000);
    host.xfer(1'b1, OFS_ACC, 32'h0000_0005, 4'hE, q);
    rc(OFS_ACC, 32'h0000_0000);
    $display("test reset_map done");
  endtask : t_reset_map

  task t_shift;
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_SHIFT, 32'h0000_00A5);
    wr(OFS_AUX, 32'h0000_000F);
    issue(OPC_SHIFT_RD);
    rc(OFS_AUX, 32'h0000_000A);
    rc(OFS_ACC, 32'h0000_0005);
    rc(OFS_SHIFT, 32'h0000_00A5);
    chk({31'h0, carry_flag}, 32'h0000_0001);
    chk({31'h0, skip_next}, 32'h0000_0000);
    $display("test shift done");
  endtask : t_shift

  task t_ptr;
    wr(OFS_ACC, 32'h0000_000F);
    wr(OFS_PTR, 32'h0000_0005);
    issue(OPC_PTR_RD);
    rc(OFS_ACC, 32'h0000_0005);
    wr(OFS_PTR, 32'h0000_0007);
    issue(OPC_PTR_RD);
    rc(OFS_ACC, 32'h0000_0007);
    $display("test ptr done");
  endtask : t_ptr

  task t_cmp;
    wr(OFS_AUX, 32'h0000_0003);
    wr(OFS_ACC, 32'h0000_000C);
    issue(OPC_CMP_WR);
    chk({24'h00_0000, cmp_value}, 32'h0000_0000);
    rc(OFS_ACC, 32'h0000_000C);
    rc(OFS_AUX, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0003);
    issue(OPC_CMP_WR);
    chk({24'h00_0000, cmp_value}, 32'h0000_003C);
    rc(OFS_CMP, 32'h0000_003C);
    $display("test cmp done");
  endtask : t_cmp

  task t_irq;
    wr(OFS_IRQ1, 32'h0000_0009);
    issue(OPC_IRQ_RD);
    rc(OFS_ACC, 32'h0000_0009);
    // Six executed, last kind is the interrupt-control read
    rc(OFS_STATUS, 32'h0000_0610);
    issue(10'h3FF);
    rc(OFS_STATUS, 32'h0000_0702);
    chk({31'h0, carry_flag}, 32'h0000_0001);
    $display("test irq done");
  endtask : t_irq

  // Clock enable low holds a pending instruction until it rises again
  task t_freeze;
    wr(OFS_AUX, 32'h0000_0005);
    wr(OFS_ACC, 32'h0000_000A);
    wr(OFS_INSTR, {22'h00_0000, OPC_CMP_WR});
    ce <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({31'h0, exec_done}, 32'h0000_0000);
    chk({24'h00_0000, cmp_value}, 32'h0000_003C);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({31'h0, exec_done}, 32'h0000_0001);
    chk({24'h00_0000, cmp_value}, 32'h0000_005A);
    $display("test freeze done");
  endtask : t_freeze

  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_map();
    t_shift();
    t_ptr();
    t_cmp();
    t_irq();
    t_freeze();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
endmodule : nibble_transfer_instr_exec_tb_top
